/* design/rx_status_defs.vh */
// Offsets, field positions, reset values and timing for the receiver status block.
// Assumes a 7-bit register address from the control port and 8-bit register data.

`ifndef RX_STATUS_DEFS_VH
`define RX_STATUS_DEFS_VH

`define ADDR_PRE_FIRST_HIGH 7'h14
`define ADDR_PRE_FIRST_LOW 7'h15
`define ADDR_PRE_SECOND_HIGH 7'h16
`define ADDR_PRE_SECOND_LOW 7'h17
`define ADDR_FAULT_FLAGS 7'h18
`define ADDR_FAULT_MASK 7'h19

`define BIT_SAMPLE_INVALID 7
`define BIT_EMPHASIS 6
`define BIT_COMPRESSED 5
`define BIT_BURST_SEEN 4
`define BIT_STATUS_CHECK_FAIL 3
`define BIT_INPUT_ABSENT 2
`define BIT_CODING_ERROR 1
`define BIT_PLL_LOCK 0

// Flags 3 and 1 are sticky, all others follow a level
`define STICKY_FLAGS 8'h0a

`define RESET_FAULT_MASK 8'h00
`define RESET_PREAMBLE 16'h0000
`define UNMAPPED_READ 8'h00

// Read data appears this many cycles after the request
`define READ_LATENCY 1

`endif

/* design/fault_flag_cell.v */
// One receiver fault flag with its pending-event latch.
// Assumes set, level and read-clear inputs all come from the same clock domain.
`timescale 1ns/100ps

module fault_flag_cell #(
   parameter STICKY = 0
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Event sources
   input wire level_in,
   input wire change_in,
   input wire set_in,
   // Host read of the flag register
   input wire read_clr,
   // State
   output wire flag_out,
   output wire event_out
);

   reg flag_reg;
   reg flag_next;
   reg event_reg;
   reg event_next;
   wire raise;

   // Level flags raise on any change; sticky flags raise on each set pulse
   assign raise = STICKY ? set_in : ((level_in != flag_reg) | change_in);

   always @* begin
      if (STICKY) begin
         // Set wins over a read in the same cycle
         if (set_in)
            flag_next = 1'b1;
         else if (read_clr)
            flag_next = 1'b0;
         else
            flag_next = flag_reg;
      end else begin
         flag_next = level_in;
      end
      // A pending event survives a read that meets a new event
      if (raise)
         event_next = 1'b1;
      else if (read_clr)
         event_next = 1'b0;
      else
         event_next = event_reg;
   end

   always @(posedge clk) begin
      if (!resetn) begin
         flag_reg <= 1'b0;
         event_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         event_reg <= event_next;
      end
   end

   assign flag_out = flag_reg;
   assign event_out = event_reg;

endmodule // fault_flag_cell

/* design/rx_status_regs.v */
// Receiver status registers: burst preamble words, fault flags and fault mask.
// Assumes the receiver core and the control port decoder run on clk, so no
// synchroniser is needed; reads and writes arrive as one-cycle strobes.
`timescale 1ns/100ps
`include "rx_status_defs.vh"

module rx_status_regs #(
   parameter ADDR_W = 7,
   parameter DATA_W = 8,
   parameter PRE_W = 16,
   parameter KIND_W = 5
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Register access from the control port
   input wire rd_en,
   input wire wr_en,
   input wire [ADDR_W-1:0] addr,
   input wire [DATA_W-1:0] wdata,
   output wire [DATA_W-1:0] rdata,
   output wire rdata_valid,
   // Receiver stream status levels
   input wire rx_sample_invalid_flag,
   input wire emphasis_in,
   input wire cs_compressed_in,
   input wire [KIND_W-1:0] compressed_kind_in,
   input wire burst_seen_in,
   input wire input_absent_flag,
   input wire pll_locked_in,
   // Receiver error pulses
   input wire status_check_fail_flag,
   input wire biphase_error_in,
   input wire parity_error_in,
   // Burst preamble capture
   input wire preamble_strobe,
   input wire subframe_mode,
   input wire [PRE_W-1:0] preamble_first_in,
   input wire [PRE_W-1:0] preamble_second_in,
   input wire [PRE_W-1:0] preamble_first_chb_in,
   // Interrupt request
   output wire fault_irq
);

   localparam NFLAG = 8;

   // Address match helper used by both read and write decode
   function is_addr;
      input [ADDR_W-1:0] a;
      input [ADDR_W-1:0] ref_addr;
      begin
         is_addr = (a == ref_addr);
      end
   endfunction

   // High byte of a preamble word
   function [DATA_W-1:0] hi_byte;
      input [PRE_W-1:0] w;
      begin
         hi_byte = w[PRE_W-1:PRE_W-DATA_W];
      end
   endfunction

   // Low byte of a preamble word
   function [DATA_W-1:0] lo_byte;
      input [PRE_W-1:0] w;
      begin
         lo_byte = w[DATA_W-1:0];
      end
   endfunction

   reg [PRE_W-1:0] pre_first_reg;
   reg [PRE_W-1:0] pre_first_next;
   reg [PRE_W-1:0] pre_second_reg;
   reg [PRE_W-1:0] pre_second_next;
   reg [DATA_W-1:0] fault_mask_reg;
   reg [DATA_W-1:0] fault_mask_next;
   reg [KIND_W-1:0] kind_reg;
   reg [DATA_W-1:0] rdata_reg;
   reg [DATA_W-1:0] rdata_next;
   reg rdata_valid_reg;
   reg irq_reg;
   reg irq_next;

   wire flags_read;
   wire mask_write;
   wire kind_change;
   wire compressed_now;
   wire [NFLAG-1:0] level_vec;
   wire [NFLAG-1:0] change_vec;
   wire [NFLAG-1:0] set_vec;
   wire [NFLAG-1:0] flag_vec;
   wire [NFLAG-1:0] event_vec;

   // Only a real read of the flag register clears anything
   assign flags_read = rd_en & is_addr(addr, `ADDR_FAULT_FLAGS);
   assign mask_write = wr_en & is_addr(addr, `ADDR_FAULT_MASK);

   // Compressed data is present either by channel status or by a found burst
   assign compressed_now = cs_compressed_in | burst_seen_in;

   // A new data kind while still compressed counts as a fresh event
   assign kind_change = cs_compressed_in & (compressed_kind_in != kind_reg);

   // Level inputs, one per flag position
   assign level_vec[`BIT_SAMPLE_INVALID] = rx_sample_invalid_flag;
   assign level_vec[`BIT_EMPHASIS] = emphasis_in;
   assign level_vec[`BIT_COMPRESSED] = cs_compressed_in;
   assign level_vec[`BIT_BURST_SEEN] = burst_seen_in;
   assign level_vec[`BIT_STATUS_CHECK_FAIL] = 1'b0;
   assign level_vec[`BIT_INPUT_ABSENT] = input_absent_flag;
   assign level_vec[`BIT_CODING_ERROR] = 1'b0;
   assign level_vec[`BIT_PLL_LOCK] = pll_locked_in;

   // Extra change sources beyond the level itself
   assign change_vec[`BIT_SAMPLE_INVALID] = 1'b0;
   assign change_vec[`BIT_EMPHASIS] = 1'b0;
   assign change_vec[`BIT_COMPRESSED] = kind_change;
   assign change_vec[`BIT_BURST_SEEN] = 1'b0;
   assign change_vec[`BIT_STATUS_CHECK_FAIL] = 1'b0;
   assign change_vec[`BIT_INPUT_ABSENT] = 1'b0;
   assign change_vec[`BIT_CODING_ERROR] = 1'b0;
   assign change_vec[`BIT_PLL_LOCK] = 1'b0;

   // Set pulses for the sticky flags
   assign set_vec[`BIT_SAMPLE_INVALID] = 1'b0;
   assign set_vec[`BIT_EMPHASIS] = 1'b0;
   assign set_vec[`BIT_COMPRESSED] = 1'b0;
   assign set_vec[`BIT_BURST_SEEN] = 1'b0;
   assign set_vec[`BIT_STATUS_CHECK_FAIL] = status_check_fail_flag;
   assign set_vec[`BIT_INPUT_ABSENT] = 1'b0;
   assign set_vec[`BIT_CODING_ERROR] = biphase_error_in | parity_error_in;
   assign set_vec[`BIT_PLL_LOCK] = 1'b0;

   genvar gi;
   generate
      for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
         localparam [NFLAG-1:0] STICKY_MAP = `STICKY_FLAGS;
         fault_flag_cell #(
            .STICKY(STICKY_MAP[gi])
         ) u_cell (
            .clk(clk),
            .resetn(resetn),
            .level_in(level_vec[gi]),
            .change_in(change_vec[gi]),
            .set_in(set_vec[gi]),
            .read_clr(flags_read),
            .flag_out(flag_vec[gi]),
            .event_out(event_vec[gi])
         );
      end
   endgenerate

   // Track the compressed data kind; audio resets it so a return re-arms
   always @(posedge clk) begin
      if (!resetn) begin
         kind_reg <= {KIND_W{1'b0}};
      end else if (cs_compressed_in) begin
         kind_reg <= compressed_kind_in;
      end else begin
         kind_reg <= {KIND_W{1'b0}};
      end
   end

   // Preamble capture: words are zeroed as soon as the stream is audio again
   always @* begin
      pre_first_next = pre_first_reg;
      pre_second_next = pre_second_reg;
      if (!compressed_now) begin
         pre_first_next = `RESET_PREAMBLE;
         pre_second_next = `RESET_PREAMBLE;
      end else if (preamble_strobe) begin
         pre_first_next = preamble_first_in;
         if (subframe_mode)
            pre_second_next = preamble_first_chb_in;
         else
            pre_second_next = preamble_second_in;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         pre_first_reg <= `RESET_PREAMBLE;
         pre_second_reg <= `RESET_PREAMBLE;
      end else begin
         pre_first_reg <= pre_first_next;
         pre_second_reg <= pre_second_next;
      end
   end

   // Mask register, the only writable location here
   always @* begin
      if (mask_write)
         fault_mask_next = wdata;
      else
         fault_mask_next = fault_mask_reg;
   end

   always @(posedge clk) begin
      if (!resetn)
         fault_mask_reg <= `RESET_FAULT_MASK;
      else
         fault_mask_reg <= fault_mask_next;
   end

   // Read mux; the flag byte shows state before the read's own clear
   always @* begin
      rdata_next = rdata_reg;
      if (rd_en) begin
         case (addr)
            `ADDR_PRE_FIRST_HIGH: rdata_next = hi_byte(pre_first_reg);
            `ADDR_PRE_FIRST_LOW: rdata_next = lo_byte(pre_first_reg);
            `ADDR_PRE_SECOND_HIGH: rdata_next = hi_byte(pre_second_reg);
            `ADDR_PRE_SECOND_LOW: rdata_next = lo_byte(pre_second_reg);
            `ADDR_FAULT_FLAGS: rdata_next = flag_vec;
            `ADDR_FAULT_MASK: rdata_next = fault_mask_reg;
            default: rdata_next = `UNMAPPED_READ;
         endcase
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         rdata_reg <= `UNMAPPED_READ;
         rdata_valid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rdata_valid_reg <= rd_en;
      end
   end

   // Interrupt follows pending events through the mask, one cycle late
   always @* begin
      irq_next = |(event_vec & fault_mask_reg);
   end

   always @(posedge clk) begin
      if (!resetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_next;
   end

   assign rdata = rdata_reg;
   assign rdata_valid = rdata_valid_reg;
   assign fault_irq = irq_reg;

endmodule // rx_status_regs

/* bench/host_port_model.sv */
// Host side of the control port: issues register reads and writes.
// Assumes each call starts just after a rising edge of clk.
`timescale 1ns/100ps
module host_port_model (
   // Clock
   input wire clk,
   // Register port
   output reg rd_en,
   output reg wr_en,
   output reg [6:0] addr,
   output reg [7:0] wdata,
   input wire [7:0] rdata,
   input wire rdata_valid
);
   initial begin
      rd_en = 1'b0;
      wr_en = 1'b0;
      addr = 7'h7f;
      wdata = 8'hff;
   end
   // Idle cycle after each access; idle address is inverted so stale use shows
   task rd(input [6:0] a, output [7:0] d);
      begin
         rd_en = 1'b1;
         addr = a;
         @(posedge clk);
         #1;
         rd_en = 1'b0;
         addr = ~a;
         d = (rdata_valid === 1'b1) ? rdata : 8'hxx;
         @(posedge clk);
         #1;
      end
   endtask
   task wr(input [6:0] a, input [7:0] v);
      begin
         wr_en = 1'b1;
         addr = a;
         wdata = v;
         @(posedge clk);
         #1;
         wr_en = 1'b0;
         addr = ~a;
         wdata = ~v;
         @(posedge clk);
         #1;
      end
   endtask
endmodule // host_port_model

/* bench/rx_status_props.sv */
// Port-level checker for the receiver status registers.
// Assumes one clock domain and the defines of the design header.
`timescale 1ns/100ps
`include "rx_status_defs.vh"
module rx_status_props (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Register port
   input wire rd_en,
   input wire wr_en,
   input wire [6:0] addr,
   input wire [7:0] wdata,
   input wire [7:0] rdata,
   input wire rdata_valid,
   // Status inputs
   input wire rx_sample_invalid_flag,
   input wire emphasis_in,
   input wire cs_compressed_in,
   input wire burst_seen_in,
   input wire input_absent_flag,
   input wire pll_locked_in,
   input wire status_check_fail_flag,
   // Interrupt
   input wire fault_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   reg mask_set_reg;
   wire flag_rd = rd_en && addr == `ADDR_FAULT_FLAGS;
   always @(posedge clk) begin
      if (!resetn)
         mask_set_reg <= 1'b0;
      else if (wr_en && addr == `ADDR_FAULT_MASK && wdata != 8'h00)
         mask_set_reg <= 1'b1;
   end
   sequence no_compressed;
      !cs_compressed_in && !burst_seen_in;
   endsequence
   sequence fail_then_read;
      status_check_fail_flag ##1 !rd_en ##1 flag_rd;
   endsequence
   a_read_answered: assert property (rd_en |=> rdata_valid) else $error("read not answered");
   a_valid_needs_read: assert property (rdata_valid |-> $past(rd_en))
      else $error("answer without read");
   a_rdata_holds: assert property (!rd_en |=> $stable(rdata)) else $error("rdata moved");
   a_fail_kept: assert property (fail_then_read |=> rdata[3])
      else $error("check fail flag lost");
   a_mask_gates_irq: assert property (!mask_set_reg |-> !fault_irq)
      else $error("irq with mask clear");
   a_validity_emph: assert property (flag_rd && $past(resetn, 2) |=>
      rdata[7:6] == $past({rx_sample_invalid_flag, emphasis_in}, 2)) else $error("bits 7:6");
   a_level_flags: assert property (flag_rd && $past(resetn, 2) |=>
      {rdata[5:4], rdata[2], rdata[0]} == $past({cs_compressed_in, burst_seen_in,
      input_absent_flag, pll_locked_in}, 2)) else $error("level flag wrong");
   a_unmapped_zero: assert property (rd_en && (addr < 7'h14 || addr > 7'h19) |=>
      rdata == 8'h00) else $error("unmapped read not zero");
   a_preamble_zero: assert property (no_compressed ##1 no_compressed ##0
      (rd_en && addr >= 7'h14 && addr <= 7'h17) |=> rdata == 8'h00) else $error("preamble");
endmodule // rx_status_props

/* bench/tb.sv */
// Self-checking bench for the receiver status registers.
// Assumes the host model drives the register port, the bench the status inputs.
`timescale 1ns/100ps
`include "rx_status_defs.vh"
module tb;
   reg clk, resetn, inv, emph, cs, burst, absent, pll, crc, biph, par, strobe, subf;
   reg [4:0] kind;
   reg [15:0] pre1, pre2, preb;
   wire rd_en, wr_en, rdata_valid, fault_irq;
   wire [6:0] addr;
   wire [7:0] wdata, rdata;
   reg [7:0] d;
   reg [31:0] w;
   integer failures, cmp_count, cyc, i;
   host_port_model host_u (.clk(clk), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid));
   rx_status_regs dut_u (.clk(clk), .resetn(resetn), .rd_en(rd_en), .wr_en(wr_en),
      .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid),
      .rx_sample_invalid_flag(inv), .emphasis_in(emph), .cs_compressed_in(cs),
      .compressed_kind_in(kind), .burst_seen_in(burst), .input_absent_flag(absent),
      .pll_locked_in(pll), .status_check_fail_flag(crc), .biphase_error_in(biph),
      .parity_error_in(par), .preamble_strobe(strobe), .subframe_mode(subf),
      .preamble_first_in(pre1), .preamble_second_in(pre2),
      .preamble_first_chb_in(preb), .fault_irq(fault_irq));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         failures = failures + 1;
         summarize;
      end
   end
   task summarize;
      begin
         $display("failures=%0d compares=%0d", failures, cmp_count);
         if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task check(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rd_chk(input [6:0] a, input [7:0] exp);
      begin
         host_u.rd(a, d);
         check(d, exp);
      end
   endtask
   task step(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   // Own loop index, so callers looping on i are not disturbed
   task pre_chk(input [31:0] v);
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            rd_chk(7'h14 + k[6:0], v[31 - 8 * k -: 8]);
      end
   endtask
   initial begin
      {resetn, inv, emph, cs, burst, absent, pll, crc, biph, par, strobe, subf} = 12'h000;
      {kind, pre1, pre2, preb} = 53'h0;
      failures = 0;
      cmp_count = 0;
      cyc = 0;
      step(8);
      resetn = 1'b1;
      step(2);
      rd_chk(`ADDR_FAULT_FLAGS, 8'h00);
      rd_chk(`ADDR_FAULT_MASK, 8'h00);
      rd_chk(7'h13, 8'h00);
      rd_chk(7'h1f, 8'h00);
      pre_chk(32'h0);
      $display("reset test done");
      {inv, emph, cs, burst, absent, pll} = 6'h3f;
      kind = 5'h03;
      step(2);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf5);
      host_u.wr(`ADDR_FAULT_MASK, 8'hff);
      step(3);
      check({7'h0, fault_irq}, 8'h00);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf5);
      kind = 5'h07;
      step(3);
      check({7'h0, fault_irq}, 8'h01);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf5);
      step(2);
      check({7'h0, fault_irq}, 8'h00);
      pll = 1'b0;
      step(3);
      check({7'h0, fault_irq}, 8'h01);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf4);
      $display("level test done");
      host_u.wr(`ADDR_FAULT_MASK, 8'h08);
      rd_chk(`ADDR_FAULT_MASK, 8'h08);
      pll = 1'b1;
      step(3);
      check({7'h0, fault_irq}, 8'h00);
      crc = 1'b1;
      step(1);
      crc = 1'b0;
      step(2);
      check({7'h0, fault_irq}, 8'h01);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hfd);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf5);
      fork
         host_u.rd(`ADDR_FAULT_FLAGS, d);
         begin
            crc = 1'b1;
            step(1);
            crc = 1'b0;
         end
      join
      check(d, 8'hf5);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hfd);
      biph = 1'b1;
      step(1);
      biph = 1'b0;
      step(1);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf7);
      par = 1'b1;
      step(1);
      par = 1'b0;
      step(1);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf7);
      rd_chk(`ADDR_FAULT_FLAGS, 8'hf5);
      $display("sticky test done");
      {pre1, pre2, preb} = 48'h1234_5678_9abc;
      for (i = 0; i < 2; i = i + 1) begin
         subf = i[0];
         strobe = 1'b1;
         step(1);
         strobe = 1'b0;
         step(1);
         w = subf ? {pre1, preb} : {pre1, pre2};
         pre_chk(w);
      end
      {cs, burst} = 2'b00;
      step(2);
      pre_chk(32'h0);
      $display("preamble test done");
      summarize;
   end
endmodule // tb
bind rx_status_regs rx_status_props props_u (.clk(clk), .resetn(resetn), .rd_en(rd_en),
   .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid),
   .rx_sample_invalid_flag(rx_sample_invalid_flag), .emphasis_in(emphasis_in),
   .cs_compressed_in(cs_compressed_in), .burst_seen_in(burst_seen_in),
   .input_absent_flag(input_absent_flag), .pll_locked_in(pll_locked_in),
   .status_check_fail_flag(status_check_fail_flag), .fault_irq(fault_irq));
